// >>> shared/mfr_pkg.sv
package mfr_pkg;
    localparam int DW = 16;
    localparam int AW = 22;
    localparam int UPW = 6;
    localparam int CFG_ASYNC_BIT = 15;
    localparam int CFG_WS_LSB = 11;
    localparam int CFG_WS_W = 4;
    localparam logic [15:0] CFG_RESET = 16'hC800;
    localparam logic [15:0] UPPER_BOTTOM = 16'h0000;
    localparam logic [15:0] UPPER_TOP = 16'hFFFF;
    localparam int GROUP_LOG2 = 3;
    localparam int BOUNDARY_LOG2 = 7;
    localparam logic [3:0] WS_FULL_OFFSET = 4'h8;
    localparam logic [3:0] WS_PLUS1 = 4'h9;
    localparam logic [3:0] WS_PLUS2_LO = 4'hA;
    localparam logic [3:0] WS_PLUS2_HI = 4'hD;
    localparam logic [3:0] BOUNDARY_WAITS = 4'h1;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic address_valid_n;
    } mfr_pins_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] upper;
    } mfr_xfer_t;

    typedef enum logic [1:0] {L_IDLE, L_LAT, L_STREAM, L_WAIT} mfr_lstate_t;
endpackage

// >>> hdl/mfr_sync.sv
`timescale 1ns/1ps
module mfr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds the second only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // mfr_sync

// >>> hdl/mfr_hs.sv
`timescale 1ns/1ps
module mfr_hs #(
    parameter int W = 32
) (
    input wire logic src_clk,
    input wire logic src_rstn,
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [W-1:0] src_data,
    input wire logic dst_clk,
    input wire logic dst_rstn,
    output logic dst_valid,
    output logic [W-1:0] dst_data
);
    logic tog_q;
    logic ack_s;
    logic tog_s;
    logic seen_q;
    logic [W-1:0] data_q;

    assign src_ready = (tog_q == ack_s);
    assign dst_valid = tog_s ^ seen_q;
    // Word held stable until the far side has acknowledged it
    assign dst_data = data_q;

    always_ff @(posedge src_clk or negedge src_rstn) begin
        if (!src_rstn) begin
            tog_q <= 1'b0;
            data_q <= '0;
        end else if (src_valid && src_ready) begin
            tog_q <= ~tog_q;
            data_q <= src_data;
        end
    end

    always_ff @(posedge dst_clk or negedge dst_rstn) begin
        if (!dst_rstn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= tog_s;
        end
    end

    mfr_sync #(.W(1)) u_fwd (
        .clk(dst_clk),
        .rstn(dst_rstn),
        .d(tog_q),
        .q(tog_s)
    );

    mfr_sync #(.W(1)) u_back (
        .clk(src_clk),
        .rstn(src_rstn),
        .d(seen_q),
        .q(ack_s)
    );
endmodule // mfr_hs

// >>> hdl/mfr_read_if.sv
// What this block does
// - Configuration bit 15 set selects asynchronous reads.
// - Burst reads only run while configuration bit 15 is zero.
// - Muxed async: address taken when address-valid rises, output enable high.
// - Split async: upper address stored on address-valid rise with output enable low.
// - Split async: lower address latched on next address-valid rise, enable high.
// - After initial waits, first word then one word per clock, address advancing.
// - Ready output shows initial latency and every later wait.
// - Bus driven only with select and enable low and latency met.
// - Muxed mode: enable high only floats outputs, burst holds its place.
// - Split burst: upper 16 bits taken when enable and address-valid low.
// - Split burst: lower 16 bits taken when address-valid low, enable high.
// - Split burst: enable ignored after it rises until next lower capture.
// - Extra waits whenever the burst crosses a 128-word boundary.
// - Unaligned start may add waits after the first eight-word group.
// - At 8 waits, start offset n gives n waits after offset 7.
// - At 9 waits, one more wait before the next group.
// - At 10 to 13 waits, two more waits before the next group.
// - Burst wraps to zero; ends on select high, reset, or new address.
// - Split mode reuses last upper address when none is supplied.
// - Reset leaves the block in asynchronous mode.
// - Reset sets upper address to zeros or ones per boot strap.
`timescale 1ns/1ps
module mfr_read_if (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic burst_clk,
    input wire mfr_pkg::mfr_pins_t ctl_pins,
    input wire logic [mfr_pkg::DW-1:0] bus_in,
    output logic [mfr_pkg::DW-1:0] bus_out,
    output logic bus_oe,
    output logic rdy,
    input wire logic [mfr_pkg::UPW-1:0] addr_hi_pins,
    input wire logic split_high_low_address_mode,
    input wire logic boot_top,
    input wire logic [15:0] cfg_word,
    input wire logic cfg_load,
    output logic [mfr_pkg::AW-1:0] async_rd_addr,
    input wire logic [mfr_pkg::DW-1:0] async_rd_data,
    output logic [mfr_pkg::AW-1:0] burst_rd_addr,
    input wire logic [mfr_pkg::DW-1:0] burst_rd_data
);
    import mfr_pkg::*;

    function automatic logic [3:0] group_waits(input logic [2:0] off, input logic [3:0] ws);
        logic [4:0] sum;
        logic [3:0] w;
        sum = {2'b00, off} + {1'b0, ws};
        if (ws >= WS_FULL_OFFSET) begin
            w = {1'b0, off};
        end else if (sum > 5'h08) begin
            w = 4'(sum - 5'h08);
        end else begin
            w = 4'h0;
        end
        if (ws == WS_PLUS1) begin
            w = 4'(w + 4'h1);
        end else if (ws >= WS_PLUS2_LO && ws <= WS_PLUS2_HI) begin
            w = 4'(w + 4'h2);
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reference clock side: configuration, upper address, async reads
    mfr_pins_t r_pins;
    logic [DW-1:0] r_bus;
    logic [UPW-1:0] r_hi;
    logic r_split;
    logic r_boot_top;
    logic r_avd_prev_q;
    logic r_avd_rise;
    logic [15:0] r_cfg_q;
    logic r_async;
    logic [1:0] r_init_q;
    logic [15:0] r_upper_q;
    logic [AW-1:0] a_addr_q;
    logic a_valid_q;
    logic [DW-1:0] a_data_q;
    logic a_oe;
    mfr_xfer_t r_sent_q;
    mfr_xfer_t r_xfer;
    logic r_tx_ready;
    logic r_tx_valid;
    logic r_rx_valid;
    logic [15:0] r_rx_upper;

    mfr_sync #(.W(4 + DW + UPW + 2)) u_rsync (
        .clk(ref_clk),
        .rstn(rstn),
        .d({ctl_pins, bus_in, addr_hi_pins, split_high_low_address_mode, boot_top}),
        .q({r_pins, r_bus, r_hi, r_split, r_boot_top})
    );

    // Synchroniser wakes at zero, so edges only count once the strap has settled
    assign r_avd_rise = (r_init_q == STRAP_SETTLE) && r_pins.address_valid_n && !r_avd_prev_q;
    assign r_async = r_cfg_q[CFG_ASYNC_BIT];
    assign r_xfer = '{cfg: r_cfg_q, upper: r_upper_q};
    assign r_tx_valid = (r_init_q == STRAP_SETTLE) && (r_xfer != r_sent_q);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_avd_prev_q <= 1'b1;
        end else begin
            r_avd_prev_q <= r_pins.address_valid_n;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_cfg_q <= CFG_RESET;
        end else if (cfg_load) begin
            r_cfg_q <= cfg_word;
        end
    end

    // Strap is read only once the synchroniser has settled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_init_q <= 2'h0;
            r_upper_q <= UPPER_BOTTOM;
        end else if (r_init_q != STRAP_SETTLE) begin
            r_init_q <= 2'(r_init_q + 2'h1);
            r_upper_q <= r_boot_top ? UPPER_TOP : UPPER_BOTTOM;
        end else if (r_async && r_split && r_avd_rise && !r_pins.ce_n && !r_pins.oe_n) begin
            r_upper_q <= r_bus;
        end else if (r_rx_valid) begin
            r_upper_q <= r_rx_upper;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_addr_q <= '0;
            a_valid_q <= 1'b0;
        end else if (r_pins.ce_n || !r_async || !r_pins.address_valid_n) begin
            a_valid_q <= 1'b0;
        end else if (r_avd_rise && r_pins.oe_n) begin
            // Lower half reuses the stored upper half in split mode
            a_addr_q <= {(r_split ? r_upper_q[UPW-1:0] : r_hi), r_bus};
            a_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_data_q <= '0;
        end else begin
            a_data_q <= async_rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_sent_q <= '0;
        end else if (r_tx_valid && r_tx_ready) begin
            r_sent_q <= r_xfer;
        end
    end

    assign async_rd_addr = a_addr_q;
    assign a_oe = a_valid_q && !r_pins.ce_n && !r_pins.oe_n && r_pins.we_n;

    ////////////////////////////////////////////////////////////////////////
    // Link clock side: burst engine
    logic [1:0] l_rst_q;
    logic l_rstn;
    logic l_split;
    logic l_rx_valid;
    mfr_xfer_t l_rx;
    logic [15:0] l_cfg_q;
    logic [15:0] l_upper_q;
    logic l_dirty_q;
    logic l_tx_ready;
    logic l_async;
    logic [3:0] l_ws;
    logic l_cap_upper;
    logic l_cap_lower;
    mfr_lstate_t l_state_q;
    logic [AW-1:0] l_addr_q;
    logic [3:0] l_cnt_q;
    logic [3:0] l_gw_q;
    logic [3:0] l_wc_q;
    logic l_first_q;
    logic l_taken_q;
    logic l_rdy_q;
    logic l_valid_q;
    logic l_drive_q;
    logic [DW-1:0] l_data_q;
    logic [3:0] l_need;
    logic l_wait_enter;
    logic l_fetch;
    logic l_oe;

    always_ff @(posedge burst_clk or negedge rstn) begin
        if (!rstn) begin
            l_rst_q <= 2'b00;
        end else begin
            l_rst_q <= {l_rst_q[0], 1'b1};
        end
    end
    assign l_rstn = l_rst_q[1];

    mfr_sync #(.W(1)) u_lsync (
        .clk(burst_clk),
        .rstn(l_rstn),
        .d(split_high_low_address_mode),
        .q(l_split)
    );

    assign l_async = l_cfg_q[CFG_ASYNC_BIT];
    assign l_ws = l_cfg_q[CFG_WS_LSB +: CFG_WS_W];
    // Host pins are synchronous to the burst clock here
    assign l_cap_upper = !l_async && l_split && !ctl_pins.ce_n
        && !ctl_pins.address_valid_n && !ctl_pins.oe_n;
    assign l_cap_lower = !l_async && !ctl_pins.ce_n
        && !ctl_pins.address_valid_n && ctl_pins.oe_n;
    assign l_need = 4'((l_first_q ? l_gw_q : 4'h0)
        + ((l_addr_q[BOUNDARY_LOG2-1:0] == '0) ? BOUNDARY_WAITS : 4'h0));
    assign l_wait_enter = (l_state_q == L_STREAM) && !ctl_pins.oe_n && !l_taken_q
        && (l_addr_q[GROUP_LOG2-1:0] == '0) && (l_need != 4'h0);
    assign l_fetch = !ctl_pins.oe_n && (((l_state_q == L_LAT) && (l_cnt_q == 4'h0))
        || ((l_state_q == L_STREAM) && !l_wait_enter)
        || ((l_state_q == L_WAIT) && (l_wc_q == 4'h0)));

    always_ff @(posedge burst_clk or negedge l_rstn) begin
        if (!l_rstn) begin
            l_cfg_q <= CFG_RESET;
            l_upper_q <= UPPER_BOTTOM;
            l_dirty_q <= 1'b0;
        end else if (l_cap_upper) begin
            l_upper_q <= bus_in;
            l_dirty_q <= 1'b1;
        end else begin
            if (l_rx_valid) begin
                l_cfg_q <= l_rx.cfg;
                l_upper_q <= l_rx.upper;
            end
            if (l_tx_ready) begin
                l_dirty_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge burst_clk or negedge l_rstn) begin
        if (!l_rstn) begin
            l_state_q <= L_IDLE;
            l_addr_q <= '0;
            l_cnt_q <= 4'h0;
            l_gw_q <= 4'h0;
            l_wc_q <= 4'h0;
            l_first_q <= 1'b0;
            l_taken_q <= 1'b0;
            l_rdy_q <= 1'b0;
            l_valid_q <= 1'b0;
        end else if (ctl_pins.ce_n || l_async || l_cap_upper) begin
            l_state_q <= L_IDLE;
            l_rdy_q <= 1'b0;
            l_valid_q <= 1'b0;
        end else if (l_cap_lower) begin
            l_addr_q <= {(l_split ? l_upper_q[UPW-1:0] : addr_hi_pins), bus_in};
            l_cnt_q <= (l_ws == 4'h0) ? 4'h0 : 4'(l_ws - 4'h1);
            l_state_q <= L_LAT;
            l_rdy_q <= 1'b0;
            l_valid_q <= 1'b0;
            l_taken_q <= 1'b0;
        end else begin
            if (l_fetch) begin
                l_addr_q <= 22'(l_addr_q + 22'h1);
                l_rdy_q <= 1'b1;
                l_valid_q <= 1'b1;
                l_taken_q <= 1'b0;
                l_state_q <= L_STREAM;
                if (l_addr_q[GROUP_LOG2-1:0] == '0) begin
                    l_first_q <= 1'b0;
                end
            end
            case (l_state_q)
                L_LAT: begin
                    if (l_cnt_q != 4'h0) begin
                        l_cnt_q <= 4'(l_cnt_q - 4'h1);
                    end
                    if (l_fetch) begin
                        l_gw_q <= group_waits(l_addr_q[GROUP_LOG2-1:0], l_ws);
                        l_first_q <= 1'b1;
                    end
                end
                L_STREAM: begin
                    if (l_wait_enter) begin
                        l_wc_q <= 4'(l_need - 4'h1);
                        l_state_q <= L_WAIT;
                        l_rdy_q <= 1'b0;
                        l_taken_q <= 1'b1;
                    end
                end
                L_WAIT: begin
                    if (l_wc_q != 4'h0) begin
                        l_wc_q <= 4'(l_wc_q - 4'h1);
                    end
                end
                default: begin
                    l_state_q <= l_state_q;
                end
            endcase
        end
    end

    // Previous word stays on the bus through inserted waits
    always_ff @(posedge burst_clk or negedge l_rstn) begin
        if (!l_rstn) begin
            l_data_q <= '0;
        end else if (l_fetch) begin
            l_data_q <= burst_rd_data;
        end
    end

    // Split mode must not drive while the host puts the next upper half out
    always_ff @(posedge burst_clk or negedge l_rstn) begin
        if (!l_rstn) begin
            l_drive_q <= 1'b0;
        end else if (ctl_pins.ce_n || l_cap_upper) begin
            l_drive_q <= 1'b0;
        end else if (l_cap_lower) begin
            l_drive_q <= 1'b1;
        end else if (l_split && ctl_pins.oe_n && (l_state_q != L_IDLE)) begin
            l_drive_q <= 1'b0;
        end
    end

    assign burst_rd_addr = l_addr_q;
    // In muxed mode enable high only floats the bus; the engine keeps its place
    assign l_oe = l_drive_q && l_valid_q && !ctl_pins.ce_n && !ctl_pins.oe_n;

    ////////////////////////////////////////////////////////////////////////
    // Crossings and pin outputs
    mfr_hs #(.W(32)) u_to_link (
        .src_clk(ref_clk),
        .src_rstn(rstn),
        .src_valid(r_tx_valid),
        .src_ready(r_tx_ready),
        .src_data(r_xfer),
        .dst_clk(burst_clk),
        .dst_rstn(l_rstn),
        .dst_valid(l_rx_valid),
        .dst_data(l_rx)
    );

    mfr_hs #(.W(16)) u_to_ref (
        .src_clk(burst_clk),
        .src_rstn(l_rstn),
        .src_valid(l_dirty_q),
        .src_ready(l_tx_ready),
        .src_data(l_upper_q),
        .dst_clk(ref_clk),
        .dst_rstn(rstn),
        .dst_valid(r_rx_valid),
        .dst_data(r_rx_upper)
    );

    assign bus_out = r_async ? a_data_q : l_data_q;
    assign bus_oe = r_async ? a_oe : l_oe;
    assign rdy = r_async ? 1'b1 : l_rdy_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] l_since_q;
    always_ff @(posedge burst_clk or negedge l_rstn) begin
        if (!l_rstn) begin
            l_since_q <= 4'h0;
        end else if (l_cap_lower) begin
            l_since_q <= 4'h0;
        end else if (l_since_q != 4'hF) begin
            l_since_q <= 4'(l_since_q + 4'h1);
        end
    end

    sequence s_fetch;
        l_fetch && !ctl_pins.ce_n && !l_cap_lower && !l_cap_upper && !l_async;
    endsequence
    sequence s_wait_two;
        (l_state_q == L_WAIT) ##1 (l_state_q == L_WAIT);
    endsequence

    async_idle_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        l_async |=> (l_state_q == L_IDLE) && !l_rdy_q)
        else $error("burst engine active in async mode");
    lower_cap_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        l_cap_lower |=> (l_state_q == L_LAT) && (l_addr_q[DW-1:0] == $past(bus_in)))
        else $error("lower address not latched");
    upper_cap_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        l_cap_upper |=> (l_upper_q == $past(bus_in)) && !l_drive_q)
        else $error("upper address not captured");
    first_word_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        ($past(l_state_q) == L_LAT && l_state_q == L_STREAM && l_ws >= 4'h1)
        |-> l_since_q == l_ws)
        else $error("initial latency wrong");
    advance_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        s_fetch |=> (l_addr_q == 22'($past(l_addr_q) + 22'h1)) && l_rdy_q)
        else $error("burst address did not advance");
    wait_hold_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        s_wait_two |-> !l_rdy_q && $stable(l_data_q))
        else $error("data moved during wait");
    drive_gate_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        l_oe |-> !ctl_pins.ce_n && !ctl_pins.oe_n && (l_state_q inside {L_STREAM, L_WAIT}))
        else $error("bus driven outside burst window");
    split_release_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        (l_split && ctl_pins.oe_n && !l_cap_lower && l_state_q != L_IDLE) |=> !l_drive_q)
        else $error("split mode kept driving");
    ce_end_a: assert property (@(posedge burst_clk) disable iff (!l_rstn)
        ctl_pins.ce_n |=> (l_state_q == L_IDLE) && !l_oe)
        else $error("burst not ended by select");
    async_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (r_avd_rise && r_pins.oe_n && !r_pins.ce_n && r_async)
        |=> a_valid_q && (a_addr_q[DW-1:0] == $past(r_bus)))
        else $error("async address not latched");
    boot_upper_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (r_init_q == 2'h2) |=> (r_upper_q == (r_boot_top ? UPPER_TOP : UPPER_BOTTOM)))
        else $error("boot upper address wrong");
endmodule // mfr_read_if

// >>> tb/mfr_host_model.sv
`timescale 1ns/1ps
module mfr_host_model (
    input wire logic ref_clk,
    output logic burst_clk,
    output mfr_pkg::mfr_pins_t ctl_pins,
    output logic [15:0] bus_in
);
    import mfr_pkg::*;
    bit run = 1'b0;

    // Burst clock stands still between frames; odd start offset keeps phase unrelated
    initial begin
        burst_clk = 1'b0;
        ctl_pins = '{1'b1, 1'b1, 1'b1, 1'b1};
        bus_in = 16'h0000;
        #3.3;
        forever begin
            #7.5;
            if (run) begin
                burst_clk = ~burst_clk;
            end
        end
    end

    task automatic clk_go();
        run = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Async cycle: address with enables high, pulse, then output enable
    task automatic async_read(input logic [15:0] a);
        @(posedge ref_clk);
        ctl_pins <= '{1'b0, 1'b1, 1'b1, 1'b0};
        bus_in <= a;
        repeat (2) @(posedge ref_clk);
        ctl_pins.address_valid_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Released bus shows inverse, never the stale address
        bus_in <= ~a;
        ctl_pins.oe_n <= 1'b0;
    endtask

    task automatic async_end();
        @(posedge ref_clk);
        ctl_pins.ce_n <= 1'b1;
        ctl_pins.oe_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Address-valid low for exactly one clock, enable high meanwhile
    task automatic burst_start(input logic [15:0] a);
        @(posedge burst_clk);
        ctl_pins <= '{1'b0, 1'b1, 1'b1, 1'b0};
        bus_in <= a;
        @(posedge burst_clk);
        ctl_pins.address_valid_n <= 1'b1;
        ctl_pins.oe_n <= 1'b0;
        bus_in <= ~a;
    endtask

    // Upper half: enable and address-valid low together for one clock
    task automatic burst_upper(input logic [15:0] a);
        @(posedge burst_clk);
        ctl_pins <= '{1'b0, 1'b0, 1'b1, 1'b0};
        bus_in <= a;
    endtask

    task automatic set_oe(input logic v);
        @(posedge burst_clk);
        ctl_pins.oe_n <= v;
    endtask

    task automatic burst_end();
        @(posedge burst_clk);
        ctl_pins.ce_n <= 1'b1;
        ctl_pins.oe_n <= 1'b1;
        @(posedge burst_clk);
        @(negedge burst_clk);
        run = 1'b0;
    endtask
endmodule // mfr_host_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import mfr_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic burst_clk;
    mfr_pins_t ctl_pins;
    logic [DW-1:0] bus_in;
    logic [DW-1:0] bus_out;
    logic [DW-1:0] async_rd_data;
    logic [DW-1:0] burst_rd_data;
    logic bus_oe;
    logic rdy;
    logic cfg_load = 1'b0;
    logic [15:0] cfg_word = CFG_RESET;
    logic [UPW-1:0] addr_hi = 6'h15;
    logic split_mode = 1'b0;
    logic boot_top = 1'b0;
    logic [AW-1:0] async_rd_addr;
    logic [AW-1:0] burst_rd_addr;
    int err_total = 0;
    int num_checks = 0;
    // Wait counts kept at 7 or more for a 66.7 MHz link clock
    logic [15:0] t_start [9] = '{16'h0078, 16'h0103, 16'h0100, 16'h0103, 16'h0107,
        16'h0100, 16'h0103, 16'h0103, 16'h0103};
    logic [3:0] t_ws [9] = '{4'h7, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hD};
    int t_wait [9] = '{1, 2, 0, 3, 7, 1, 4, 5, 5};

    always #4 ref_clk = ~ref_clk;

    // Array contents made from the address so words sharing an upper address all differ
    function automatic logic [15:0] word_of(input logic [AW-1:0] a);
        return a[15:0] ^ 16'hA5C3 ^ {10'h000, a[21:16]};
    endfunction
    assign async_rd_data = word_of(async_rd_addr);
    assign burst_rd_data = word_of(burst_rd_addr);

    mfr_host_model host (.ref_clk(ref_clk), .burst_clk(burst_clk), .ctl_pins(ctl_pins),
        .bus_in(bus_in));

    mfr_read_if dut (.ref_clk(ref_clk), .rstn(rstn), .burst_clk(burst_clk),
        .ctl_pins(ctl_pins), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .rdy(rdy),
        .addr_hi_pins(addr_hi), .split_high_low_address_mode(split_mode), .boot_top(boot_top),
        .cfg_word(cfg_word), .cfg_load(cfg_load), .async_rd_addr(async_rd_addr),
        .async_rd_data(async_rd_data), .burst_rd_addr(burst_rd_addr),
        .burst_rd_data(burst_rd_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Link clock runs so the setting crosses to the burst side
    task automatic load_cfg(input logic [15:0] w);
        host.clk_go();
        @(posedge ref_clk);
        cfg_word <= w;
        cfg_load <= 1'b1;
        @(posedge ref_clk);
        cfg_load <= 1'b0;
        repeat (40) @(posedge ref_clk);
    endtask

    task automatic await_rdy(output int k);
        k = 0;
        do begin
            @(posedge burst_clk);
            #1;
            k++;
        end while (rdy !== 1'b1 && k < 20);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_async();
        logic [AW-1:0] a;
        a = {addr_hi, 16'h3C5A};
        host.async_read(16'h3C5A);
        repeat (10) @(posedge ref_clk);
        #1;
        chk("async_addr", 32'(async_rd_addr), 32'(a));
        chk("async_data", 32'(bus_out), 32'(word_of(a)));
        chk("async_oe", 32'(bus_oe), 32'h1);
        host.async_end();
        repeat (4) @(posedge ref_clk);
        #1;
        chk("async_off", 32'(bus_oe), 32'h0);
        $display("test async read done");
    endtask

    task automatic test_refuse();
        host.clk_go();
        host.burst_start(16'h0040);
        repeat (12) begin
            @(posedge burst_clk);
            #1;
            chk("async_rdy", 32'(rdy), 32'h1);
        end
        host.burst_end();
        $display("test burst refused done");
    endtask

    task automatic run_burst(input logic [15:0] start, input logic [3:0] ws, input int waits);
        logic [AW-1:0] a;
        int k;
        int off;
        a = {addr_hi, start};
        off = int'(start[2:0]);
        load_cfg({1'b0, ws, 11'h000});
        host.burst_start(start);
        await_rdy(k);
        chk("latency", 32'(k), 32'(ws));
        chk("first", 32'(bus_out), 32'(word_of(a)));
        chk("drive", 32'(bus_oe), 32'h1);
        for (int i = off + 1; i < 8; i++) begin
            @(posedge burst_clk);
            #1;
            chk("word", {15'h0, rdy, bus_out}, {15'h0, 1'b1, word_of(a + AW'(i - off))});
        end
        k = 0;
        do begin
            @(posedge burst_clk);
            #1;
            if (rdy !== 1'b1) begin
                k++;
                chk("hold", 32'(bus_out), 32'(word_of(a + AW'(7 - off))));
            end
        end while (rdy !== 1'b1 && k < 20);
        chk("waits", 32'(k), 32'(waits));
        chk("next", 32'(bus_out), 32'(word_of(a + AW'(8 - off))));
        host.burst_end();
        #1;
        chk("ended", 32'(bus_oe), 32'h0);
    endtask

    task automatic test_oe_gap();
        int k;
        load_cfg(16'h3800);
        host.burst_start(16'h0200);
        await_rdy(k);
        host.set_oe(1'b1);
        repeat (2) begin
            #1;
            chk("gap_oe", 32'(bus_oe), 32'h0);
            @(posedge burst_clk);
        end
        host.set_oe(1'b0);
        @(posedge burst_clk);
        #1;
        chk("resume", {30'h0, bus_oe, rdy}, 32'h3);
        chk("resume_data", 32'(bus_out), 32'(word_of({addr_hi, 16'h0202})));
        host.burst_end();
        $display("test enable gap done");
    endtask

    // Second reset with top boot strap: a lower-only access lands in the top range
    task automatic test_split();
        int k;
        @(posedge ref_clk);
        rstn <= 1'b0;
        split_mode <= 1'b1;
        boot_top <= 1'b1;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        host.async_read(16'h1234);
        repeat (10) @(posedge ref_clk);
        #1;
        chk("boot_addr", 32'(async_rd_addr), {10'h000, 6'h3F, 16'h1234});
        chk("boot_data", 32'(bus_out), 32'(word_of({6'h3F, 16'h1234})));
        host.async_end();
        load_cfg(16'h3800);
        host.burst_upper(16'h002A);
        host.burst_start(16'h0010);
        await_rdy(k);
        chk("split_first", 32'(bus_out), 32'(word_of({6'h2A, 16'h0010})));
        host.set_oe(1'b1);
        host.set_oe(1'b0);
        @(posedge burst_clk);
        #1;
        chk("split_float", 32'(bus_oe), 32'h0);
        host.burst_end();
        $display("test split address done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run is a few microseconds; generous margin
    initial begin
        #100000;
        err_total++;
        results();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        chk("rst_oe", 32'(bus_oe), 32'h0);
        chk("rst_rdy", 32'(rdy), 32'h1);
        rstn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        test_async();
        test_refuse();
        for (int i = 0; i < 9; i++) begin
            run_burst(t_start[i], t_ws[i], t_wait[i]);
        end
        $display("test burst latency table done");
        test_oe_gap();
        test_split();
        results();
    end
endmodule // testbench
